// >>> verilog/ipe_core.sv
/*
 * Interrupt priority and enable core: pending tracking, group and
 * individual enables, priority storage, per-PE selection, and the
 * restricted non-secure view of the priority mask and running priority.
 * Assumes source lines and the running priority arrive synchronised
 * to sys_clk_i; sources are edge triggered.
 */
// The plain strobed port and the placing of the registers were chosen for this implementation.
`default_nettype none

// Overview of operation
// - disabled sources still latch pending on edges or requests.
// - message sources never pend while their enable is zero.
// - with all group enables off, edges and soft requests are ignored.
// - a group enable fall withdraws that group's forwarded interrupt.
// - a cpu group enable fall releases the forwarded interrupt.
// - each source has an eight-bit unsigned priority.
// - implemented level count follows the priority width parameter.
// - unimplemented low priority bits read zero and ignore writes.
// - legal values are multiples of the step set by the width.
// - smaller priority value wins; zero is most urgent.
// - shared priorities writable except one reserved fixed source.
// - local sources keep a separate priority per processing element.
// - non-secure writes force the priority into the lower half.
// - writing all ones reads back the implemented bits only.
// - equal priorities resolve to the lowest source number.
// - best enabled unmasked source is forwarded the next cycle.
// - secure group fields read zero, ignore writes for non-secure.
// - non-secure mask view reads zero and writes dropped below 0x80.
// - non-secure view shows the shifted value when mask is high.
// - non-secure writes never take the mask from 0x80-0xff into 0x00-0x7f.
// - without monitor routing non-secure sees the unshifted values.
// - individually disabled sources are excluded from selection.
// - sources of disabled distributor groups are excluded.
module ipe_core #(
	parameter int PRIO_BITS = 5,
	parameter int FIXED_SRC = 7,
	parameter logic [7:0] FIXED_PRIO = 8'h10,
	parameter logic [7:0] MSI_SRC_MASK = 8'hc0
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire ipe_pkg::ipe_req_t req_i,
	input wire logic [ipe_pkg::IPE_NUM_SRC-1:0] src_i,
	input wire logic [ipe_pkg::IPE_NUM_PE*8-1:0] run_prio_i,
	output logic [31:0] rdata_o,
	output ipe_pkg::ipe_fwd_t [ipe_pkg::IPE_NUM_PE-1:0] fwd_o
);
	import ipe_pkg::*;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [5:0] ctrl;
		logic [IPE_NUM_SRC-1:0] en;
		logic [IPE_NUM_SRC-1:0] pend;
		logic [IPE_NUM_SRC-1:0] src_q;
		logic [IPE_NUM_SRC*2-1:0] grp;
		logic [IPE_NUM_PE*2-1:0] cpu_en;
		logic [IPE_NUM_SRC*8-1:0] sh_prio;
		logic [IPE_NUM_PE*IPE_NUM_LOCAL*8-1:0] lc_prio;
		logic [IPE_NUM_PE*8-1:0] pmask;
		logic [31:0] rdata;
		ipe_fwd_t [IPE_NUM_PE-1:0] fwd;
	} ipe_state_t;

	ipe_state_t st_r;
	ipe_state_t st_nxt;

	// 2**PRIO_BITS levels; two security states need PRIO_BITS of 5 or more
	// the mask is the only place the width enters, so every path agrees on it
	localparam logic [7:0] IMPL_MASK = 8'(8'hff << (8 - PRIO_BITS));

	// secure groups are group 0 and secure group 1
	function automatic logic grp_secure(input logic [1:0] g);
		return g != IPE_GRP_1NS;
	endfunction

	// distributor enable for a group
	function automatic logic grp_on(input logic [5:0] c, input logic [1:0] g);
		case (g)
			IPE_GRP_0: return c[IPE_CTRL_G0];
			IPE_GRP_1S: return c[IPE_CTRL_G1S];
			default: return c[IPE_CTRL_G1NS];
		endcase
	endfunction

	// non-secure shifted view of a secure priority value
	function automatic logic [7:0] ns_view(input logic [7:0] v);
		return 8'(v << 1) & IMPL_MASK;
	endfunction

	// legalise a stored priority; ns writes land in lower-urgency half
	function automatic logic [7:0] legal_prio(input logic [7:0] v, input logic ns);
		logic [7:0] r;
		r = ns ? (IPE_NS_HALF | (v >> 1)) : v;
		return r & IMPL_MASK;
	endfunction

	logic sec_ns;
	logic any_grp;
	logic [IPE_NUM_SRC-1:0] edge_hit;
	logic [IPE_NUM_SRC-1:0] soft_hit;
	logic [7:0] idx;
	logic [7:0] rd_v;
	logic [7:0] cand_p;
	logic [7:0] best_p;
	logic [7:0] best_id;
	logic best_v;
	logic [1:0] g;

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		sec_ns = req_i.ns && !st_r.ctrl[IPE_CTRL_DS];
		any_grp = st_r.ctrl[IPE_CTRL_G0] | st_r.ctrl[IPE_CTRL_G1S] | st_r.ctrl[IPE_CTRL_G1NS];
		idx = req_i.addr;
		rd_v = IPE_PRIO_ZERO;
		st_nxt.src_q = src_i;
		edge_hit = src_i & ~st_r.src_q;
		soft_hit = '0;
		st_nxt.rdata = IPE_WORD_ZERO;
		if (req_i.wr && req_i.addr == IPE_REG_SOFT_REQ) begin
			soft_hit = req_i.wdata[IPE_NUM_SRC-1:0];
		end
		// -----------------------------------------------------------
		// pending
		// -----------------------------------------------------------
		// pending latches regardless of individual enable; global off gates it
		// edges are never filtered by security, only soft requests are
		for (int i = 0; i < IPE_NUM_SRC; i++) begin
			if (sec_ns && grp_secure(st_r.grp[i*2 +: 2])) begin
				soft_hit[i] = 1'b0;
			end
			if ((edge_hit[i] || soft_hit[i]) && any_grp) begin
				if (!MSI_SRC_MASK[i] || st_r.ctrl[IPE_CTRL_MSI]) begin
					st_nxt.pend[i] = 1'b1;
				end
			end
		end
		// -----------------------------------------------------------
		// register writes
		// -----------------------------------------------------------
		// a write lands in st_nxt and is seen by selection one cycle later
		if (req_i.wr) begin
			case (req_i.addr)
				IPE_REG_CTRL: begin
					if (!sec_ns) begin
						st_nxt.ctrl = req_i.wdata[5:0];
					end else begin
						st_nxt.ctrl[IPE_CTRL_G1NS] = req_i.wdata[IPE_CTRL_G1NS];
					end
				end
				IPE_REG_SET_EN, IPE_REG_CLR_EN: begin
					for (int i = 0; i < IPE_NUM_SRC; i++) begin
						if (req_i.wdata[i] && !(sec_ns && grp_secure(st_r.grp[i*2 +: 2]))) begin
							st_nxt.en[i] = (req_i.addr == IPE_REG_SET_EN);
						end
					end
				end
				IPE_REG_PEND: begin
					// clear-pending; a same-cycle set wins
					for (int i = 0; i < IPE_NUM_SRC; i++) begin
						if (req_i.wdata[i] && !edge_hit[i] && !soft_hit[i]
								&& !(sec_ns && grp_secure(st_r.grp[i*2 +: 2]))) begin
							st_nxt.pend[i] = 1'b0;
						end
					end
				end
				IPE_REG_SEC: begin
					if (!sec_ns) begin
						st_nxt.grp = req_i.wdata[IPE_NUM_SRC*2-1:0];
					end
				end
				IPE_REG_CPU_EN: begin
					st_nxt.cpu_en = req_i.wdata[IPE_NUM_PE*2-1:0];
				end
				default: begin
				end
			endcase
			// shared priorities
			if (idx >= IPE_REG_SHPRIO && idx < IPE_REG_SHPRIO + 8'(IPE_NUM_SRC)) begin
				g = st_r.grp[(idx - IPE_REG_SHPRIO)*2 +: 2];
				if (!(idx - IPE_REG_SHPRIO == 8'(FIXED_SRC)) && !(sec_ns && grp_secure(g))) begin
					st_nxt.sh_prio[(idx - IPE_REG_SHPRIO)*8 +: 8] =
						legal_prio(req_i.wdata[7:0], sec_ns);
				end
			end
			// per-pe local priorities; secure local sources hidden from ns
			if (idx >= IPE_REG_LCPRIO && idx < IPE_REG_LCPRIO + 8'(IPE_NUM_PE*IPE_NUM_LOCAL)) begin
				g = st_r.grp[(int'(idx - IPE_REG_LCPRIO) % IPE_NUM_LOCAL)*2 +: 2];
				if (!(sec_ns && grp_secure(g))) begin
					st_nxt.lc_prio[(idx - IPE_REG_LCPRIO)*8 +: 8] =
						legal_prio(req_i.wdata[7:0], sec_ns);
				end
			end
			// priority mask per pe, word holds pe index in bits 11:8
			if (idx == IPE_REG_PMASK && int'(req_i.wdata[11:8]) < IPE_NUM_PE) begin
				if (!req_i.ns || st_r.ctrl[IPE_CTRL_DS] || !st_r.ctrl[IPE_CTRL_FIQ]) begin
					st_nxt.pmask[req_i.wdata[11:8]*8 +: 8] = req_i.wdata[7:0] & IMPL_MASK;
				end else if (st_r.pmask[req_i.wdata[11:8]*8 +: 8] >= IPE_NS_HALF) begin
					st_nxt.pmask[req_i.wdata[11:8]*8 +: 8] =
						legal_prio(req_i.wdata[7:0], 1'b1);
				end
			end
		end
		// -----------------------------------------------------------
		// register reads
		// -----------------------------------------------------------
		// data stand the cycle after the strobe, zero in every other cycle
		// unmapped words fall through every arm and read zero
		if (req_i.rd) begin
			case (req_i.addr)
				IPE_REG_CTRL: st_nxt.rdata[5:0] = sec_ns ?
					(st_r.ctrl & 6'(1 << IPE_CTRL_G1NS)) : st_r.ctrl;
				IPE_REG_SET_EN, IPE_REG_CLR_EN: st_nxt.rdata[IPE_NUM_SRC-1:0] = st_r.en;
				IPE_REG_PEND: st_nxt.rdata[IPE_NUM_SRC-1:0] = st_r.pend;
				IPE_REG_SEC: st_nxt.rdata[IPE_NUM_SRC*2-1:0] = sec_ns ? '0 : st_r.grp;
				IPE_REG_CPU_EN: st_nxt.rdata[IPE_NUM_PE*2-1:0] = st_r.cpu_en;
				IPE_REG_HPPI: begin
					for (int p = 0; p < IPE_NUM_PE; p++) begin
						st_nxt.rdata[p*8 +: 8] = st_r.fwd[p].id;
					end
				end
				IPE_REG_PMASK, IPE_REG_RUNPRIO: begin
					for (int p = 0; p < IPE_NUM_PE; p++) begin
						rd_v = (req_i.addr == IPE_REG_PMASK) ? st_r.pmask[p*8 +: 8]
							: (run_prio_i[p*8 +: 8] & IMPL_MASK);
						if (req_i.ns && !st_r.ctrl[IPE_CTRL_DS] && st_r.ctrl[IPE_CTRL_FIQ]) begin
							rd_v = (st_r.pmask[p*8 +: 8] < IPE_NS_HALF) ? IPE_PRIO_ZERO
								: ns_view(rd_v);
						end
						st_nxt.rdata[p*8 +: 8] = rd_v;
					end
				end
				default: begin
					if (idx >= IPE_REG_SHPRIO && idx < IPE_REG_SHPRIO + 8'(IPE_NUM_SRC)) begin
						rd_v = st_r.sh_prio[(idx - IPE_REG_SHPRIO)*8 +: 8];
						g = st_r.grp[(idx - IPE_REG_SHPRIO)*2 +: 2];
						st_nxt.rdata[7:0] = !sec_ns ? rd_v
							: (grp_secure(g) ? IPE_PRIO_ZERO : ns_view(rd_v));
					end else if (idx >= IPE_REG_LCPRIO
							&& idx < IPE_REG_LCPRIO + 8'(IPE_NUM_PE*IPE_NUM_LOCAL)) begin
						rd_v = st_r.lc_prio[(idx - IPE_REG_LCPRIO)*8 +: 8];
						g = st_r.grp[(int'(idx - IPE_REG_LCPRIO) % IPE_NUM_LOCAL)*2 +: 2];
						st_nxt.rdata[7:0] = !sec_ns ? rd_v
							: (grp_secure(g) ? IPE_PRIO_ZERO : ns_view(rd_v));
					end
				end
			endcase
		end
		// -----------------------------------------------------------
		// selection
		// -----------------------------------------------------------
		// selection per pe; local sources use the per-pe priority bank
		// scanning from the top with <= lets the lowest equal source win
		// one flat compare chain: cheap at eight sources, not for hundreds
		for (int p = 0; p < IPE_NUM_PE; p++) begin
			best_v = 1'b0;
			best_p = IPE_PRIO_IDLE;
			best_id = IPE_PRIO_ZERO;
			for (int i = IPE_NUM_SRC - 1; i >= 0; i--) begin
				g = st_r.grp[i*2 +: 2];
				cand_p = (i < IPE_NUM_LOCAL) ? st_r.lc_prio[(p*IPE_NUM_LOCAL + i)*8 +: 8]
					: st_r.sh_prio[i*8 +: 8];
				if (st_r.pend[i] && st_r.en[i]
						&& grp_on(st_r.ctrl, g)
						&& st_r.cpu_en[p*2 + (g == IPE_GRP_0 ? 0 : 1)]
						&& (cand_p & IMPL_MASK) < st_r.pmask[p*8 +: 8]
						&& (cand_p & IMPL_MASK) < run_prio_i[p*8 +: 8]
						&& (cand_p <= best_p)) begin
					best_v = 1'b1;
					best_p = cand_p;
					best_id = 8'(i);
				end
			end
			st_nxt.fwd[p].valid = best_v;
			st_nxt.fwd[p].id = best_id;
			st_nxt.fwd[p].prio = best_p;
		end
		if (!rst_n_i) begin
			st_nxt = '0;
			st_nxt.sh_prio[FIXED_SRC*8 +: 8] = FIXED_PRIO & IMPL_MASK;
		end
	end

	// ---------------------------------------------------------------
	// register stage
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		st_r <= st_nxt;
	end

	assign rdata_o = st_r.rdata;
	assign fwd_o = st_r.fwd;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_prio_low_bits: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(st_r.sh_prio & ~{IPE_NUM_SRC{IMPL_MASK}}) == '0)
		else $error("unimplemented priority bits set");
	a_fixed_prio_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		st_r.sh_prio[FIXED_SRC*8 +: 8] == (FIXED_PRIO & IMPL_MASK))
		else $error("reserved priority changed");
	a_msi_no_pend: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!st_r.ctrl[IPE_CTRL_MSI] && $past(rst_n_i) |=> ((st_r.pend & ~$past(st_r.pend)
		& MSI_SRC_MASK) == '0))
		else $error("message source pended while disabled");
	// the forward shows last cycle's state, so index the past vectors by today's id
	a_fwd_enabled: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		fwd_o[0].valid |-> 1'($past(st_r.en) >> fwd_o[0].id))
		else $error("disabled source forwarded");
	a_grp_withdraw: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		fwd_o[0].valid |-> grp_on($past(st_r.ctrl), 2'($past(st_r.grp) >> (fwd_o[0].id * 2))))
		else $error("forward not withdrawn");
	a_cpu_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		st_r.cpu_en[1:0] == 2'h0 |=> !fwd_o[0].valid)
		else $error("forward not released");
	a_fwd_masked: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		fwd_o[0].valid |-> fwd_o[0].prio < $past(st_r.pmask[7:0]))
		else $error("forward above mask");
	a_ns_mask_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$past(st_r.pmask[7:0]) >= IPE_NS_HALF && $past(req_i.wr) && $past(req_i.ns)
		&& $past(st_r.ctrl[IPE_CTRL_FIQ]) && !$past(st_r.ctrl[IPE_CTRL_DS])
		&& $past(req_i.wdata[11:8]) == 4'h0
		&& $past(req_i.addr) == IPE_REG_PMASK |-> st_r.pmask[7:0] >= IPE_NS_HALF)
		else $error("ns mask write reached secure half");
	a_ns_read_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.rd && req_i.ns && req_i.addr == IPE_REG_PMASK && !st_r.ctrl[IPE_CTRL_DS]
		&& st_r.ctrl[IPE_CTRL_FIQ] && st_r.pmask[7:0] < IPE_NS_HALF |=> rdata_o[7:0] == 8'h00)
		else $error("ns mask read not zero");
	a_ns_view_high: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.rd && req_i.ns && req_i.addr == IPE_REG_PMASK && !st_r.ctrl[IPE_CTRL_DS]
		&& st_r.ctrl[IPE_CTRL_FIQ] && st_r.pmask[7:0] >= IPE_NS_HALF
		|=> rdata_o[7:0] == (8'($past(st_r.pmask[7:0]) << 1) & IMPL_MASK))
		else $error("ns mask read not shifted");
	a_ns_mask_drop: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.wr && req_i.ns && req_i.addr == IPE_REG_PMASK && req_i.wdata[11:8] == 4'h0
		&& !st_r.ctrl[IPE_CTRL_DS] && st_r.ctrl[IPE_CTRL_FIQ]
		&& st_r.pmask[7:0] < IPE_NS_HALF |=> $stable(st_r.pmask[7:0]))
		else $error("ns mask write not ignored");
	a_ns_ctrl_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.wr && sec_ns && req_i.addr == IPE_REG_CTRL
		|=> (st_r.ctrl & ~6'(1 << IPE_CTRL_G1NS))
		== ($past(st_r.ctrl) & ~6'(1 << IPE_CTRL_G1NS)))
		else $error("ns write changed secure control");

	// pending checks
	a_pend_kept: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		any_grp && (edge_hit & ~MSI_SRC_MASK) != '0
		|=> (st_r.pend & $past(edge_hit & ~MSI_SRC_MASK)) == $past(edge_hit & ~MSI_SRC_MASK))
		else $error("edge on a source did not pend");
	a_groups_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!any_grp |=> (st_r.pend & ~$past(st_r.pend)) == '0)
		else $error("pending set with all groups off");

	c_forward: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i) fwd_o[0].valid);
	c_withdraw: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$fell(fwd_o[0].valid));
	c_ns_read: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.rd && req_i.ns && req_i.addr == IPE_REG_PMASK);
	c_ns_mask_write: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.wr && req_i.ns && req_i.addr == IPE_REG_PMASK && st_r.pmask[7:0] >= IPE_NS_HALF);
	c_soft_pend: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		req_i.wr && req_i.addr == IPE_REG_SOFT_REQ && any_grp);

endmodule

`default_nettype wire

// >>> verilog/ipe_pkg.sv
/*
 * Shared constants and types for the interrupt priority and enable block:
 * register indices, field layout, widths and carrier structs.
 * Assumes a single clock domain and a plain register port master.
 */
`default_nettype none

package ipe_pkg;

	// ---------------------------------------------------------------
	// sizes
	// ---------------------------------------------------------------
	localparam int IPE_NUM_SRC = 8;
	localparam int IPE_NUM_PE = 2;
	localparam int IPE_NUM_LOCAL = 4;
	localparam int IPE_ADDR_W = 8;
	localparam int IPE_PRIO_W = 8;

	// ---------------------------------------------------------------
	// register indices (word address on the plain port)
	// ---------------------------------------------------------------
	localparam logic [7:0] IPE_REG_CTRL = 8'h00;
	localparam logic [7:0] IPE_REG_SET_EN = 8'h01;
	localparam logic [7:0] IPE_REG_CLR_EN = 8'h02;
	localparam logic [7:0] IPE_REG_PEND = 8'h03;
	localparam logic [7:0] IPE_REG_SOFT_REQ = 8'h04;
	localparam logic [7:0] IPE_REG_CPU_EN = 8'h05;
	localparam logic [7:0] IPE_REG_PMASK = 8'h06;
	localparam logic [7:0] IPE_REG_RUNPRIO = 8'h07;
	localparam logic [7:0] IPE_REG_HPPI = 8'h08;
	localparam logic [7:0] IPE_REG_SEC = 8'h09;
	localparam logic [7:0] IPE_REG_SHPRIO = 8'h10;
	localparam logic [7:0] IPE_REG_LCPRIO = 8'h20;

	// ---------------------------------------------------------------
	// control register bits
	// ---------------------------------------------------------------
	localparam int IPE_CTRL_G0 = 0;
	localparam int IPE_CTRL_G1S = 1;
	localparam int IPE_CTRL_G1NS = 2;
	localparam int IPE_CTRL_MSI = 3;
	localparam int IPE_CTRL_DS = 4;
	localparam int IPE_CTRL_FIQ = 5;

	// ---------------------------------------------------------------
	// values
	// ---------------------------------------------------------------
	localparam logic [7:0] IPE_PRIO_ZERO = 8'h00;
	localparam logic [7:0] IPE_PRIO_IDLE = 8'hff;
	localparam logic [7:0] IPE_NS_HALF = 8'h80;
	localparam logic [31:0] IPE_WORD_ZERO = 32'h0000_0000;
	localparam logic [1:0] IPE_GRP_0 = 2'h0;
	localparam logic [1:0] IPE_GRP_1S = 2'h1;
	localparam logic [1:0] IPE_GRP_1NS = 2'h2;

	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic ns;
		logic [7:0] addr;
		logic [31:0] wdata;
	} ipe_req_t;

	// forwarded interrupt to one processing element
	typedef struct packed {
		logic valid;
		logic [7:0] id;
		logic [7:0] prio;
	} ipe_fwd_t;

endpackage

`default_nettype wire

// >>> verif/ipe_src_model.sv
/*
 * Far-side model for ipe_core: the interrupt source lines and the
 * running priority of each processing element.
 * Assumes one clock shared with the block; the bench calls its tasks.
 */
`default_nettype none

module ipe_src_model (
	input wire logic sys_clk_i,
	output var logic [7:0] src_o,
	output var logic [15:0] run_prio_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// idle levels
	// ---------------------------------------------------------------
	// lines start low and no interrupt is active on any element
	initial begin
		src_o = 8'h00;
		run_prio_o = 16'hffff;
	end

	// ---------------------------------------------------------------
	// stimulus tasks
	// ---------------------------------------------------------------
	// a line stays high two cycles so one clean rising edge is seen
	task automatic fire(input logic [7:0] m);
		@(posedge sys_clk_i);
		src_o <= src_o | m;
		repeat (2) @(posedge sys_clk_i);
		src_o <= src_o & ~m;
	endtask

	// running priority changes only right after an edge
	task automatic set_run(input int pe, input logic [7:0] v);
		@(posedge sys_clk_i);
		run_prio_o[pe*8 +: 8] <= v;
	endtask
endmodule

`default_nettype wire

// >>> verif/tb_top.sv
/*
 * Self-checking bench for ipe_core: reads queue an expectation that a
 * watcher checks one cycle after each read strobe.
 * Assumes the far-side model ipe_src_model and the ipe_pkg register map.
 */
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ipe_pkg::*;

	logic sys_clk_i;
	logic rst_n_i;
	ipe_req_t req;
	logic [7:0] src;
	logic [15:0] run_prio;
	logic [31:0] rdata;
	ipe_fwd_t [IPE_NUM_PE-1:0] fwd;
	logic [63:0] notes[$];
	logic [63:0] note;
	logic rd_q;
	logic [7:0] v;
	int error_cnt;
	int num_checks;
	int cyc;

	// ---------------------------------------------------------------
	// clock and instances
	// ---------------------------------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	ipe_core ipe_core_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req), .src_i(src),
		.run_prio_i(run_prio), .rdata_o(rdata), .fwd_o(fwd));
	ipe_src_model ipe_src_model_i (.sys_clk_i(sys_clk_i), .src_o(src), .run_prio_o(run_prio));

	// ---------------------------------------------------------------
	// watcher and timeout
	// ---------------------------------------------------------------
	// read data stands only in the cycle after the strobe, so look there
	always @(posedge sys_clk_i) begin
		if (rd_q) begin
			note = notes.pop_front();
			`CHK("rdata", note[63:32], rdata & note[31:0])
		end
		rd_q <= req.rd;
	end

	// the whole run needs well under this many cycles
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one-cycle strobes; the idle cycle after keeps each strobe driven once per step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ns = 1'b0);
		@(posedge sys_clk_i);
		req <= '{wr: 1'b1, rd: 1'b0, ns: ns, addr: a, wdata: d};
		@(posedge sys_clk_i);
		req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic ns = 1'b0);
		notes.push_back({e, m});
		@(posedge sys_clk_i);
		req <= '{wr: 1'b0, rd: 1'b1, ns: ns, addr: a, wdata: 32'h0};
		@(posedge sys_clk_i);
		req <= '0;
	endtask

	// forwarding lags state by a cycle; five cycles leave margin
	task automatic fchk(input logic vld, input logic [7:0] id, input logic [7:0] p);
		repeat (5) @(posedge sys_clk_i);
		if (vld) `CHK("fwd0", {vld, id, p}, fwd[0])
		else `CHK("fwd0_valid", 1'b0, fwd[0].valid)
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		req = '0;
		rst_n_i = 1'b0;
		rd_q = 1'b0;
		error_cnt = 0;
		num_checks = 0;
		cyc = 0;
		void'($urandom(32'hfc24));
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		@(posedge sys_clk_i);
		`CHK("fwd0_rst", 17'h0, fwd[0])
		// priority width, fixed source and per-element local copies
		rd(IPE_REG_SHPRIO + 8'h07, 32'h10, 32'hff);
		wr(IPE_REG_CLR_EN, 32'h10);
		wr(IPE_REG_SHPRIO + 8'h04, 32'hff);
		rd(IPE_REG_SHPRIO + 8'h04, 32'hf8, 32'hff);
		wr(IPE_REG_SHPRIO + 8'h07, 32'h00);
		rd(IPE_REG_SHPRIO + 8'h07, 32'h10, 32'hff);
		v = $urandom;
		wr(IPE_REG_SHPRIO + 8'h05, {24'h0, v});
		rd(IPE_REG_SHPRIO + 8'h05, {24'h0, v & 8'hf8}, 32'hff);
		wr(IPE_REG_LCPRIO + 8'h01, 32'h28);
		wr(IPE_REG_LCPRIO + 8'h05, 32'hb0);
		rd(IPE_REG_LCPRIO + 8'h01, 32'h28, 32'hff);
		rd(IPE_REG_LCPRIO + 8'h05, 32'hb0, 32'hff);
		$display("test priority done");
		// secure fields hidden from non-secure, non-secure writes kept in lower half
		rd(IPE_REG_SHPRIO + 8'h05, 32'h0, 32'hff, 1'b1);
		wr(IPE_REG_SHPRIO + 8'h05, 32'h00, 1'b1);
		rd(IPE_REG_SHPRIO + 8'h05, {24'h0, v & 8'hf8}, 32'hff);
		rd(IPE_REG_LCPRIO + 8'h01, 32'h0, 32'hff, 1'b1);
		wr(IPE_REG_SEC, 32'h200);
		wr(IPE_REG_SHPRIO + 8'h04, 32'h20, 1'b1);
		rd(IPE_REG_SHPRIO + 8'h04, 32'h90, 32'hff);
		wr(IPE_REG_CTRL, 32'h20);
		wr(IPE_REG_PMASK, 32'h040);
		rd(IPE_REG_PMASK, 32'h00, 32'hff, 1'b1);
		rd(IPE_REG_RUNPRIO, 32'h00, 32'hff, 1'b1);
		wr(IPE_REG_PMASK, 32'h0c0, 1'b1);
		rd(IPE_REG_PMASK, 32'h40, 32'hff);
		wr(IPE_REG_PMASK, 32'h0a0);
		wr(IPE_REG_PMASK, 32'h020, 1'b1);
		rd(IPE_REG_PMASK, 32'h90, 32'hff);
		rd(IPE_REG_PMASK, 32'h20, 32'hff, 1'b1);
		rd(IPE_REG_RUNPRIO, 32'hf0, 32'hff, 1'b1);
		wr(IPE_REG_PMASK, 32'h040);
		wr(IPE_REG_CTRL, 32'h3f, 1'b1);
		rd(IPE_REG_CTRL, 32'h24, 32'h3f);
		wr(IPE_REG_CTRL, 32'h00);
		rd(IPE_REG_PMASK, 32'h40, 32'hff, 1'b1);
		rd(8'hff, 32'h0, 32'hffffffff);
		$display("test security done");
		// pending with groups off, with sources disabled and message sources
		wr(IPE_REG_SET_EN, 32'h04);
		ipe_src_model_i.fire(8'h04);
		wr(IPE_REG_SOFT_REQ, 32'h20);
		rd(IPE_REG_PEND, 32'h00, 32'h24);
		wr(IPE_REG_CTRL, 32'h07);
		ipe_src_model_i.fire(8'h4c);
		rd(IPE_REG_PEND, 32'h0c, 32'h4c);
		wr(IPE_REG_CTRL, 32'h0f);
		ipe_src_model_i.fire(8'h40);
		rd(IPE_REG_PEND, 32'h40, 32'h40);
		wr(IPE_REG_SOFT_REQ, 32'h20);
		wr(IPE_REG_SOFT_REQ, 32'h01, 1'b1);
		rd(IPE_REG_PEND, 32'h60, 32'h61);
		wr(IPE_REG_PEND, 32'hff);
		$display("test pending done");
		// selection and withdrawal on element 0
		wr(IPE_REG_PMASK, 32'h0ff);
		wr(IPE_REG_CPU_EN, 32'h0f);
		wr(IPE_REG_LCPRIO, 32'h40);
		wr(IPE_REG_SET_EN, 32'h03);
		ipe_src_model_i.fire(8'h03);
		fchk(1'b1, 8'h01, 8'h28);
		rd(IPE_REG_HPPI, 32'h01, 32'hff);
		wr(IPE_REG_LCPRIO, 32'h28);
		fchk(1'b1, 8'h00, 8'h28);
		wr(IPE_REG_CLR_EN, 32'h01);
		fchk(1'b1, 8'h01, 8'h28);
		wr(IPE_REG_CTRL, 32'h0e);
		fchk(1'b0, 8'h00, 8'h00);
		wr(IPE_REG_CTRL, 32'h0f);
		fchk(1'b1, 8'h01, 8'h28);
		wr(IPE_REG_CPU_EN, 32'h0c);
		fchk(1'b0, 8'h00, 8'h00);
		wr(IPE_REG_CPU_EN, 32'h0f);
		ipe_src_model_i.set_run(0, 8'h28);
		fchk(1'b0, 8'h00, 8'h00);
		ipe_src_model_i.set_run(0, 8'h30);
		fchk(1'b1, 8'h01, 8'h28);
		wr(IPE_REG_PMASK, 32'h028);
		fchk(1'b0, 8'h00, 8'h00);
		$display("test forwarding done");
		repeat (3) @(posedge sys_clk_i);
		report_and_stop();
	end
endmodule

`default_nettype wire
